/* File: rtl/row_pkg.sv */
// row_pkg: constants shared by the relay-board end and the host controller end.
// assumes a single 100 MHz clock on both ends and a write-only two-wire link.
package row_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ            = 100_000_000;
  localparam int CLK_PER_MS        = CLK_HZ / 1000;
  localparam int WDT_TIMEOUT_S     = 30;
  localparam int TICK_MS           = 1;
  localparam int ROW_TICK_CYC      = CLK_PER_MS * TICK_MS;
  localparam int ROW_TIMEOUT_TICKS = (WDT_TIMEOUT_S * 1000) / TICK_MS;
  localparam int HB_PERIOD_MS      = 3000;
  localparam int ROW_HB_HALF_CYC   = CLK_PER_MS * (HB_PERIOD_MS / 2);
  localparam int PWRUP_MS          = 100;
  localparam int ROW_PWRUP_CYC     = CLK_PER_MS * PWRUP_MS;
  localparam int I2C_KHZ           = 100;
  localparam int ROW_SCL_QTR_CYC   = CLK_HZ / (I2C_KHZ * 1000 * 4);

  // ---------------------------------------------------------------
  // link message: address byte, switch byte, control byte
  // ---------------------------------------------------------------
  localparam logic [6:0] ROW_DEV_ADDR = 7'h20;  // arbitrary value
  localparam int ROW_SW_W      = 8;
  localparam int ROW_MSG_BYTES = 3;
  localparam int ROW_BYTE_SW   = 1;
  localparam int ROW_BYTE_CTL  = 2;
  localparam int ROW_BIT_LAST  = 8;
  // switch byte bit positions
  localparam int SW_MEAS_REF_VALVE  = 0;
  localparam int SW_ZERO_SPAN_VALVE = 1;
  localparam int SW_SAMPLE_CAL_VALV = 2;
  localparam int SW_PHOTO_HEATER    = 3;
  localparam int SW_GEN_HEATER      = 4;
  localparam int SW_SCRUB_HEATER    = 5;
  localparam int SW_PHOTO_LAMP      = 6;
  localparam int SW_GEN_LAMP        = 7;
  // control byte / register bit positions
  localparam int CTL_HEARTBEAT = 0;
  localparam int CTL_PUMP      = 1;
  localparam int CTL_AUTO_HB   = 2;
  localparam logic [7:0] ROW_SW_DEFAULT  = 8'h00;
  localparam logic       ROW_PUMP_DEFLT  = 1'b0;

  // ---------------------------------------------------------------
  // host controller register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_SWITCH   = 8'h00;
  localparam logic [7:0] REG_CONTROL  = 8'h04;
  localparam logic [7:0] REG_COMMAND  = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_INT_STAT = 8'h10;
  localparam logic [7:0] REG_INT_MASK = 8'h14;
  localparam int CMD_SEND   = 0;
  localparam int ST_BUSY    = 0;
  localparam int ST_PEND    = 1;
  localparam int ST_NACK    = 2;
  localparam int INT_DONE   = 0;
  localparam int INT_NACK   = 1;
  localparam int INT_W      = 2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage : row_pkg

/* File: rtl/row_if.sv */
// row_if: open-drain two-wire link between host controller and relay board.
// assumes both ends drive enables only; the wire levels are resolved here.
interface row_if;
  logic scl_oe;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;

  // wired-and with pull-ups
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe_host | sda_oe_dev);

  modport host (input scl, input sda, output scl_oe, output sda_oe_host);
  modport dev  (input scl, input sda, output sda_oe_dev);
endinterface : row_if

/* File: rtl/row_hb_watch.sv */
// row_hb_watch: heartbeat supervisor with its own millisecond tick.
// assumes hb is synchronous to hclk.
module row_hb_watch
  import row_pkg::*;
#(
  parameter int TICK_CYC    = ROW_TICK_CYC,
  parameter int TIMEOUT_TCK = ROW_TIMEOUT_TICKS
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic arm,
  input  wire logic hb,
  output logic      hb_edge,
  output logic      timeout
);
  logic        hb_prev_r;
  logic [31:0] div_r;
  logic [31:0] tck_r;
  logic        tick;

  assign hb_edge = arm & (hb ^ hb_prev_r);
  assign tick    = (div_r == 32'(TICK_CYC - 1));
  // pulse once when level has stood still for the whole window
  assign timeout = arm & ~hb_edge & tick & (tck_r == 32'(TIMEOUT_TCK - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hb_prev_r <= 1'b0;
      div_r     <= 32'h0;
      tck_r     <= 32'h0;
    end else begin
      hb_prev_r <= hb;
      if (!arm || hb_edge) begin
        div_r <= 32'h0;
        tck_r <= 32'h0;
      end else begin
        div_r <= tick ? 32'h0 : div_r + 32'h1;
        if (tick && tck_r != 32'(TIMEOUT_TCK))
          tck_r <= tck_r + 32'h1;
      end
    end
  end
endmodule : row_hb_watch

/* File: rtl/row_device.sv */
// row_device: relay-board end; receives switch commands over the two-wire
// link and drives valve, heater and lamp switches under heartbeat watch.
// assumes scl/sda are synchronous to hclk and the host is the only master.

// Behaviour
// - host toggles heartbeat about every 1.5 seconds (3 second period)
// - timeout forces valves, lamps, heaters off
// - timeout leaves sample pump running
// - power-up holds outputs and link at defaults
// - decode link messages, set switch outputs
// - valve switch on applies solenoid supply
// - cal indicator lit for span gas
// - host picks zero or span inlet
// - host picks sample or cal stream
// - measure/reference valve cycled by host command
// - host reaches board through bus transceiver
module row_device
  import row_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR    = ROW_DEV_ADDR,
  parameter int         PWRUP_CYC   = ROW_PWRUP_CYC,
  parameter int         TICK_CYC    = ROW_TICK_CYC,
  parameter int         TIMEOUT_TCK = ROW_TIMEOUT_TICKS
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  row_if.dev                       link,
  output logic [ROW_SW_W-1:0]      switch_out,
  output logic                     sample_pump_run,
  output logic                     heartbeat_indicator,
  output logic                     cal_gas_select_indicator,
  output logic                     wdt_forced,
  output logic                     powerup_hold
);

  // ---------------------------------------------------------------
  // types and state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_ADDR   = 3'b001,
    RX_ACK    = 3'b010,
    RX_DATA   = 3'b011,
    RX_IGNORE = 3'b100
  } row_rx_t;

  row_rx_t               st_r;
  row_rx_t               st_nxt;
  logic                  scl_prev_r;
  logic                  sda_prev_r;
  logic [7:0]            shift_r;
  logic [3:0]            bit_cnt_r;
  logic [1:0]            byte_idx_r;
  logic                  ack_oe_r;
  logic [31:0]           pwr_cnt_r;
  logic                  pwr_done_r;
  logic                  host_ctl_r;
  logic [ROW_SW_W-1:0]   sw_r;
  logic                  hb_r;
  logic                  pump_r;
  logic                  forced_r;
  logic                  hb_seen_r;
  logic [ROW_SW_W-1:0]   sw_out_r;
  logic                  pump_out_r;

  // ---------------------------------------------------------------
  // line events
  // ---------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_full;
  logic addr_hit;
  logic data_done;
  logic wr_sw;
  logic wr_ctl;
  logic hb_edge;
  logic timeout;
  logic pwr_last;

  assign scl_rise   = link.scl & ~scl_prev_r;
  assign scl_fall   = ~link.scl & scl_prev_r;
  assign start_cond = scl_prev_r & link.scl & sda_prev_r & ~link.sda;
  assign stop_cond  = scl_prev_r & link.scl & ~sda_prev_r & link.sda;
  assign byte_full  = (bit_cnt_r == 4'(ROW_BIT_LAST));
  assign addr_hit   = (shift_r[7:1] == DEV_ADDR) & ~shift_r[0];
  assign data_done  = (st_r == RX_DATA) & scl_fall & byte_full;
  assign wr_sw      = data_done & (byte_idx_r == 2'(ROW_BYTE_SW));
  assign wr_ctl     = data_done & (byte_idx_r == 2'(ROW_BYTE_CTL));
  assign pwr_last   = (pwr_cnt_r == 32'(PWRUP_CYC - 1));

  // ---------------------------------------------------------------
  // power-up hold
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_cnt_r  <= 32'h0;
      pwr_done_r <= 1'b0;
    end else if (!pwr_done_r) begin
      pwr_cnt_r  <= pwr_cnt_r + 32'h1;
      pwr_done_r <= pwr_last;
    end
  end

  // ---------------------------------------------------------------
  // receiver state machine
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      RX_IDLE:   st_nxt = RX_IDLE;
      RX_ADDR: begin
        if (scl_fall && byte_full)
          st_nxt = addr_hit ? RX_ACK : RX_IGNORE;
      end
      RX_ACK: begin
        if (scl_fall)
          st_nxt = RX_DATA;
      end
      RX_DATA: begin
        if (data_done)
          st_nxt = RX_ACK;
      end
      RX_IGNORE: st_nxt = RX_IGNORE;
      default:   st_nxt = RX_IDLE;
    endcase
    if (!pwr_done_r || stop_cond)
      st_nxt = RX_IDLE;
    else if (start_cond)
      st_nxt = RX_ADDR;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r       <= RX_IDLE;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      scl_prev_r <= link.scl;
      sda_prev_r <= link.sda;
    end
  end

  // shift register, bit and byte counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 2'h0;
    end else if (start_cond || st_nxt == RX_IDLE) begin
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 2'h0;
    end else begin
      if ((st_r == RX_ADDR || st_r == RX_DATA) && scl_rise) begin
        shift_r   <= {shift_r[6:0], link.sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (st_r == RX_ACK && scl_fall) begin
        bit_cnt_r <= 4'h0;
        if (byte_idx_r != 2'(ROW_MSG_BYTES - 1))
          byte_idx_r <= byte_idx_r + 2'h1;
      end
    end
  end

  // acknowledge drive: low during the ninth clock of a taken byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ack_oe_r <= 1'b0;
    else if (st_nxt == RX_ACK && st_r != RX_ACK)
      ack_oe_r <= 1'b1;
    else if (st_nxt != RX_ACK)
      ack_oe_r <= 1'b0;
  end

  assign link.sda_oe_dev = ack_oe_r;

  // ---------------------------------------------------------------
  // heartbeat supervision
  // ---------------------------------------------------------------
  row_hb_watch #(
    .TICK_CYC    (TICK_CYC),
    .TIMEOUT_TCK (TIMEOUT_TCK)
  ) i_row_hb_watch (
    .hclk    (hclk),
    .hresetn (hresetn),
    .arm     (host_ctl_r),
    .hb      (hb_r),
    .hb_edge (hb_edge),
    .timeout (timeout)
  );

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_r       <= ROW_SW_DEFAULT;
      hb_r       <= 1'b0;
      pump_r     <= ROW_PUMP_DEFLT;
      host_ctl_r <= 1'b0;
    end else begin
      if (timeout)
        sw_r <= ROW_SW_DEFAULT;
      else if (wr_sw)
        sw_r <= shift_r;
      if (wr_ctl) begin
        hb_r       <= shift_r[CTL_HEARTBEAT];
        pump_r     <= shift_r[CTL_PUMP];
        host_ctl_r <= 1'b1;
      end
    end
  end

  // forced-off latch: set wins over release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      forced_r  <= 1'b0;
      hb_seen_r <= 1'b0;
    end else if (timeout) begin
      forced_r  <= 1'b1;
      hb_seen_r <= 1'b0;
    end else begin
      if (forced_r && hb_edge)
        hb_seen_r <= 1'b1;
      if (forced_r && hb_seen_r && wr_sw)
        forced_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output drive
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_out_r   <= ROW_SW_DEFAULT;
      pump_out_r <= ROW_PUMP_DEFLT;
    end else begin
      sw_out_r   <= (forced_r || !host_ctl_r) ? ROW_SW_DEFAULT : sw_r;
      pump_out_r <= host_ctl_r ? pump_r : ROW_PUMP_DEFLT;
    end
  end

  assign switch_out               = sw_out_r;
  assign sample_pump_run          = pump_out_r;
  assign heartbeat_indicator      = hb_r;
  assign cal_gas_select_indicator = sw_out_r[SW_ZERO_SPAN_VALVE];
  assign wdt_forced               = forced_r;
  assign powerup_hold             = ~host_ctl_r;

endmodule : row_device

/* File: rtl/row_host.sv */
// row_host: host controller end; AHB-Lite register slave that sends switch
// and heartbeat commands to the relay board as link write messages.
// assumes one AHB-Lite master, single word transfers, one clock.
module row_host
  import row_pkg::*;
#(
  parameter int         SCL_QTR_CYC = ROW_SCL_QTR_CYC,
  parameter int         HB_HALF_CYC = ROW_HB_HALF_CYC,
  parameter logic [6:0] DEV_ADDR    = ROW_DEV_ADDR
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  row_if.host              link
);

  // ---------------------------------------------------------------
  // bus slave: one wait state on every transfer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_BIT   = 2'b10,
    TX_STOP  = 2'b11
  } row_tx_t;

  logic              dp_r;
  logic              a_wr_r;
  logic [7:0]        a_addr_r;
  logic [31:0]       hrdata_r;
  logic [7:0]        sw_r;
  logic [2:0]        ctl_r;
  logic              pend_r;
  logic              nack_r;
  logic [INT_W-1:0]  int_r;
  logic [INT_W-1:0]  mask_r;
  row_tx_t           st_r;
  logic [31:0]       qdiv_r;
  logic [1:0]        ph_r;
  logic [3:0]        bit_r;
  logic [1:0]        byte_r;
  logic [7:0]        tx_sw_r;
  logic [7:0]        tx_ctl_r;
  logic              scl_oe_r;
  logic              sda_oe_r;
  logic [31:0]       hbdiv_r;

  logic              a_take;
  logic              wr;
  logic              wr_sw;
  logic              wr_ctl;
  logic              wr_cmd;
  logic              wr_int;
  logic              wr_mask;
  logic [31:0]       rd_mux;
  logic              qtick;
  logic              hb_tick;
  logic              go;
  logic              busy;
  logic              ack_slot;
  logic              ev_done;
  logic              ev_nack;
  logic [7:0]        tx_byte;
  logic              tx_bit;

  assign a_take  = hsel & hready & htrans[1];
  assign wr      = dp_r & a_wr_r;
  assign wr_sw   = wr & (a_addr_r == REG_SWITCH);
  assign wr_ctl  = wr & (a_addr_r == REG_CONTROL);
  assign wr_cmd  = wr & (a_addr_r == REG_COMMAND) & hwdata[CMD_SEND];
  assign wr_int  = wr & (a_addr_r == REG_INT_STAT);
  assign wr_mask = wr & (a_addr_r == REG_INT_MASK);
  assign busy    = (st_r != TX_IDLE);
  assign rd_mux  = (a_addr_r == REG_SWITCH)   ? {24'h0, sw_r} :
                   (a_addr_r == REG_CONTROL)  ? {29'h0, ctl_r} :
                   (a_addr_r == REG_STATUS)   ? {29'h0, nack_r, pend_r, busy} :
                   (a_addr_r == REG_INT_STAT) ? {30'h0, int_r} :
                   (a_addr_r == REG_INT_MASK) ? {30'h0, mask_r} : 32'h0;

  assign hreadyout = ~dp_r;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_r;
  assign irq       = |(int_r & mask_r);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_r     <= 1'b0;
      a_wr_r   <= 1'b0;
      a_addr_r <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      dp_r <= a_take;
      if (a_take) begin
        a_wr_r   <= hwrite;
        a_addr_r <= haddr[7:0];
      end
      if (dp_r && !a_wr_r)
        hrdata_r <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // control registers and automatic heartbeat
  // ---------------------------------------------------------------
  assign hb_tick = (hbdiv_r == 32'(HB_HALF_CYC - 1));
  assign go      = (st_r == TX_IDLE) & pend_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_r    <= ROW_SW_DEFAULT;
      ctl_r   <= 3'h0;
      pend_r  <= 1'b0;
      mask_r  <= '0;
      int_r   <= '0;
      hbdiv_r <= 32'h0;
    end else begin
      hbdiv_r <= hb_tick ? 32'h0 : hbdiv_r + 32'h1;
      if (wr_sw)
        sw_r <= hwdata[7:0];
      if (wr_ctl)
        ctl_r <= hwdata[2:0];
      else if (hb_tick && ctl_r[CTL_AUTO_HB])
        ctl_r[CTL_HEARTBEAT] <= ~ctl_r[CTL_HEARTBEAT];
      if (wr_mask)
        mask_r <= hwdata[INT_W-1:0];
      // request kept when a new one meets the start
      pend_r <= wr_cmd | (hb_tick & ctl_r[CTL_AUTO_HB]) | (pend_r & ~go);
      // write one to clear, new event wins
      int_r  <= (int_r & ~(wr_int ? hwdata[INT_W-1:0] : '0)) | {ev_nack, ev_done};
    end
  end

  // ---------------------------------------------------------------
  // link master: quarter-bit phases
  // ---------------------------------------------------------------
  assign qtick    = (qdiv_r == 32'(SCL_QTR_CYC - 1));
  assign ack_slot = (bit_r == 4'(ROW_BIT_LAST));
  assign tx_byte  = (byte_r == 2'(ROW_BYTE_SW))  ? tx_sw_r :
                    (byte_r == 2'(ROW_BYTE_CTL)) ? tx_ctl_r : {DEV_ADDR, 1'b0};
  assign tx_bit   = ack_slot ? 1'b1 : tx_byte[3'(7 - bit_r)];
  assign ev_done  = (st_r == TX_STOP) & qtick & (ph_r == 2'h3);
  assign ev_nack  = (st_r == TX_BIT) & qtick & (ph_r == 2'h2) & ack_slot & link.sda;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= TX_IDLE;
      qdiv_r   <= 32'h0;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      byte_r   <= 2'h0;
      tx_sw_r  <= 8'h00;
      tx_ctl_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      nack_r   <= 1'b0;
    end else if (go) begin
      st_r     <= TX_START;
      qdiv_r   <= 32'h0;
      ph_r     <= 2'h0;
      bit_r    <= 4'h0;
      byte_r   <= 2'h0;
      tx_sw_r  <= sw_r;
      tx_ctl_r <= {6'h0, ctl_r[CTL_PUMP], ctl_r[CTL_HEARTBEAT]};
      nack_r   <= 1'b0;
    end else if (busy) begin
      qdiv_r <= qtick ? 32'h0 : qdiv_r + 32'h1;
      if (qtick) begin
        ph_r <= ph_r + 2'h1;
        if (ev_nack)
          nack_r <= 1'b1;
        case (st_r)
          TX_START: begin
            if (ph_r == 2'h0)
              sda_oe_r <= 1'b1;
            if (ph_r == 2'h1) begin
              scl_oe_r <= 1'b1;
              st_r     <= TX_BIT;
              ph_r     <= 2'h0;
            end
          end
          TX_BIT: begin
            if (ph_r == 2'h0)
              sda_oe_r <= ~tx_bit;
            if (ph_r == 2'h1)
              scl_oe_r <= 1'b0;
            if (ph_r == 2'h3) begin
              scl_oe_r <= 1'b1;
              bit_r    <= ack_slot ? 4'h0 : bit_r + 4'h1;
              if (ack_slot && byte_r == 2'(ROW_MSG_BYTES - 1))
                st_r <= TX_STOP;
              else if (ack_slot)
                byte_r <= byte_r + 2'h1;
            end
          end
          TX_STOP: begin
            if (ph_r == 2'h0)
              sda_oe_r <= 1'b1;
            if (ph_r == 2'h1)
              scl_oe_r <= 1'b0;
            if (ph_r == 2'h2)
              sda_oe_r <= 1'b0;
            if (ph_r == 2'h3)
              st_r <= TX_IDLE;
          end
          default: st_r <= TX_IDLE;
        endcase
      end
    end
  end

  assign link.scl_oe      = scl_oe_r;
  assign link.sda_oe_host = sda_oe_r;

endmodule : row_host

/* File: verif/row_monitor.sv */
// row_monitor: concurrent checks on the link and relay-board outputs.
// assumes one clock; counts match the bench's device parameters.
module row_monitor #(
  parameter int PWRUP_CYC   = 20,
  parameter int TICK_CYC    = 100,
  parameter int TIMEOUT_TCK = 30
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       scl,
  input wire logic       sda_oe_dev,
  input wire logic [7:0] switch_out,
  input wire logic       sample_pump_run,
  input wire logic       heartbeat_indicator,
  input wire logic       cal_gas_select_indicator,
  input wire logic       wdt_forced,
  input wire logic       powerup_hold
);
  timeunit 1ns;
  timeprecision 1ns;
  int   up_cnt_r;
  int   quiet_cnt_r;
  logic hb_prev_r;
  logic hb_moved_r;
  wire  hb_chg = heartbeat_indicator ^ hb_prev_r;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_cnt_r    <= 0;
      quiet_cnt_r <= 0;
      hb_prev_r   <= 1'b0;
      hb_moved_r  <= 1'b0;
    end else begin
      up_cnt_r    <= (up_cnt_r < PWRUP_CYC) ? up_cnt_r + 1 : up_cnt_r;
      quiet_cnt_r <= (powerup_hold || hb_chg) ? 0 : quiet_cnt_r + 1;
      hb_prev_r   <= heartbeat_indicator;
      hb_moved_r  <= wdt_forced && (hb_moved_r || hb_chg);
    end
  end

  AST_FORCE_OFF:
    assert property (wdt_forced && $past(wdt_forced) |-> switch_out == 8'h00)
    else $error("switch on while forced");
  AST_PUMP_KEEP:
    assert property ($rose(wdt_forced) |-> $stable(sample_pump_run) [*4])
    else $error("pump moved at timeout");
  AST_HOLD_LINK:
    assert property (up_cnt_r < PWRUP_CYC |-> !sda_oe_dev)
    else $error("link driven in power-up");
  AST_HOLD_OFF:
    assert property (powerup_hold |-> switch_out == 8'h00)
    else $error("switch on in power-up");
  AST_SCL_HIGH:
    assert property (scl && $past(scl) |-> $stable(sda_oe_dev))
    else $error("data moved while clock high");
  AST_CAL:
    assert property (cal_gas_select_indicator == switch_out[1])
    else $error("cal indicator wrong");
  AST_RELEASE:
    assert property ($fell(wdt_forced) |-> hb_moved_r)
    else $error("released without heartbeat");
  AST_TMO_MIN:
    assert property ($rose(wdt_forced) |-> quiet_cnt_r >= (TIMEOUT_TCK - 1) * TICK_CYC - 2)
    else $error("timeout too early");
  AST_TMO_MAX:
    assert property (!wdt_forced |-> quiet_cnt_r <= (TIMEOUT_TCK + 1) * TICK_CYC + 4)
    else $error("timeout missed");

  cover property ($rose(wdt_forced));
  cover property ($fell(wdt_forced));
  cover property ($fell(powerup_hold));
  cover property (sda_oe_dev);
endmodule : row_monitor

/* File: verif/test_relay_output_watchdog.sv */
// test_relay_output_watchdog: host end and relay-board end over one link.
// assumes short power-up, tick and timeout counts on the device end.
module test_relay_output_watchdog
  import row_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PWR = 20;
  localparam int TCK = 100;
  localparam int TMO = 30;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        hb = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout, irq, pump, hbi, cal, wdt_forced, powerup_hold;
  logic [1:0]  hresp;
  logic [31:0] hrdata;
  logic [7:0]  switch_out;
  int          error_cnt = 0;
  int          checks = 0;

  always #5 hclk = ~hclk;

  row_if i_row_if ();
  row_host #(.SCL_QTR_CYC(4), .HB_HALF_CYC(3000)) i_row_host (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(i_row_if.host));
  row_device #(.PWRUP_CYC(PWR), .TICK_CYC(TCK), .TIMEOUT_TCK(TMO)) i_row_device (
    .hclk(hclk), .hresetn(hresetn), .link(i_row_if.dev), .switch_out(switch_out),
    .sample_pump_run(pump), .heartbeat_indicator(hbi), .cal_gas_select_indicator(cal),
    .wdt_forced(wdt_forced), .powerup_hold(powerup_hold));
  row_monitor #(.PWRUP_CYC(PWR), .TICK_CYC(TCK), .TIMEOUT_TCK(TMO)) i_row_monitor (
    .hclk(hclk), .hresetn(hresetn), .scl(i_row_if.scl), .sda_oe_dev(i_row_if.sda_oe_dev),
    .switch_out(switch_out), .sample_pump_run(pump), .heartbeat_indicator(hbi),
    .cal_gas_select_indicator(cal), .wdt_forced(wdt_forced), .powerup_hold(powerup_hold));

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, want);
  endtask : rdc

  // one message, then poll until busy and pending drop
  task automatic go();
    logic [31:0] r;
    wr(REG_COMMAND, 32'h1);
    do ahb(1'b0, REG_STATUS, 32'h0, r); while (r[1:0] !== 2'b00);
    @(negedge hclk);
  endtask : go

  task automatic send(input logic [7:0] sw, input logic pmp);
    hb = ~hb;
    wr(REG_SWITCH, {24'h0, sw});
    wr(REG_CONTROL, {30'h0, pmp, hb});
    go();
  endtask : send

  task automatic t_nack();
    go();
    rdc(REG_STATUS, 32'h4);
    rdc(REG_INT_STAT, 32'h3);
    chk(powerup_hold, 1'b1);
    chk(pump, 1'b0);
    chk(switch_out, 8'h00);
    wr(REG_INT_STAT, 32'h3);
    rdc(REG_INT_STAT, 32'h0);
    $display("t_nack done");
  endtask : t_nack

  task automatic t_regs();
    rdc(REG_CONTROL, 32'h0);
    wr(8'h18, 32'hffffffff);
    rdc(8'h18, 32'h0);
    rdc(REG_COMMAND, 32'h0);
    wr(REG_INT_MASK, 32'h3);
    rdc(REG_INT_MASK, 32'h3);
    wr(REG_INT_MASK, 32'h0);
    chk(hresp, HRESP_OKAY);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_switch();
    logic [7:0] pat [2];
    pat = '{8'ha5, 8'h5a};
    foreach (pat[i]) begin
      send(pat[i], 1'b1);
      chk(switch_out, pat[i]);
      chk(cal, pat[i][1]);
      chk(pump, 1'b1);
      chk(hbi, hb);
      chk(powerup_hold, 1'b0);
      chk(wdt_forced, 1'b0);
    end
    $display("t_switch done");
  endtask : t_switch

  task automatic t_irq();
    chk(irq, 1'b0);
    rdc(REG_INT_STAT, 32'h1);
    wr(REG_INT_MASK, 32'h1);
    @(negedge hclk);
    chk(irq, 1'b1);
    wr(REG_INT_STAT, 32'h1);
    @(negedge hclk);
    chk(irq, 1'b0);
    $display("t_irq done");
  endtask : t_irq

  task automatic t_wdt();
    repeat (TMO * TCK + 200) @(posedge hclk);
    @(negedge hclk);
    chk(wdt_forced, 1'b1);
    chk(switch_out, 8'h00);
    chk(pump, 1'b1);
    send(8'hff, 1'b1);
    chk(wdt_forced, 1'b1);
    chk(switch_out, 8'h00);
    send(8'h81, 1'b1);
    chk(wdt_forced, 1'b0);
    chk(switch_out, 8'h81);
    $display("t_wdt done");
  endtask : t_wdt

  // auto heartbeat: host toggles and sends on its own
  task automatic t_auto();
    wr(REG_CONTROL, 32'h6);
    wait (hbi === 1'b1);
    rdc(REG_CONTROL, 32'h7);
    chk(pump, 1'b1);
    $display("t_auto done");
  endtask : t_auto

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #300000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_nack();
    t_regs();
    t_switch();
    t_irq();
    t_wdt();
    t_auto();
    end_sim();
  end
endmodule : test_relay_output_watchdog
